// >>> verilog/swrst_pkg.sv
// Package of constants and carrier types for the switch reset and mode select block.
package swrst_pkg;

    // Width of the configuration select strap field.
    localparam int unsigned CFG_W = 4;

    // Configuration select codes.
    localparam logic [3:0] CFG_SINGLE = 4'h0;
    localparam logic [3:0] CFG_SINGLE_EE = 4'h1;
    localparam logic [3:0] CFG_SINGLE_P0UP = 4'h8;
    localparam logic [3:0] CFG_SINGLE_EE_P0DIS = 4'h9;
    localparam logic [3:0] CFG_SINGLE_EE_P0UP = 4'ha;
    localparam logic [3:0] CFG_SINGLE_EE_P2UP = 4'hb;
    localparam logic [3:0] CFG_MULTI = 4'hc;
    localparam logic [3:0] CFG_MULTI_EE = 4'hd;

    // Upstream port selection encodings.
    localparam logic [1:0] UP_DEFAULT = 2'h0;
    localparam logic [1:0] UP_PORT0 = 2'h1;
    localparam logic [1:0] UP_PORT2 = 2'h2;

    // Length of the link fundamental reset pulse in clock cycles.
    localparam logic [3:0] LINK_RST_CYCLES = 4'h8;
    localparam logic [3:0] LINK_RST_CNT_ZERO = 4'h0;
    localparam logic [3:0] LINK_RST_CNT_ONE = 4'h1;

    // Decoded operating mode carried to the rest of the switch.
    typedef struct packed {
        logic valid;       // Code maps to a defined mode.
        logic multi;       // Multi-partition operation.
        logic eeprom_init; // Load configuration from serial EEPROM.
        logic [1:0] upstream; // Upstream port choice.
        logic port0_dis;   // Port 0 disabled.
        logic port2_dis;   // Port 2 disabled.
    } swrst_mode_t;

    // Reset sequencer states.
    typedef enum logic [1:0] {
        SWRST_IN_RESET = 2'b00,
        SWRST_LINK_RST = 2'b01,
        SWRST_HALT = 2'b10,
        SWRST_RUN = 2'b11
    } swrst_state_t;

endpackage : swrst_pkg

// >>> verilog/swrst_mode_decode.sv
// Combinational decoder from configuration select code to operating mode.
`timescale 1ns/100ps
module swrst_mode_decode (
    input wire logic [3:0] cfg_code,
    output swrst_pkg::swrst_mode_t mode
);

    // Map each code onto its mode; undefined codes give an invalid, inert mode.
    always_comb begin
        mode = '0;
        mode.valid = 1'b1;
        unique case (cfg_code)
            swrst_pkg::CFG_SINGLE: begin
                mode.eeprom_init = 1'b0;
            end
            swrst_pkg::CFG_SINGLE_EE: begin
                mode.eeprom_init = 1'b1;
            end
            swrst_pkg::CFG_SINGLE_P0UP: begin
                mode.upstream = swrst_pkg::UP_PORT0;
                mode.port2_dis = 1'b1;
            end
            swrst_pkg::CFG_SINGLE_EE_P0DIS: begin
                mode.eeprom_init = 1'b1;
                mode.port0_dis = 1'b1;
            end
            swrst_pkg::CFG_SINGLE_EE_P0UP: begin
                mode.eeprom_init = 1'b1;
                mode.upstream = swrst_pkg::UP_PORT0;
                mode.port2_dis = 1'b1;
            end
            swrst_pkg::CFG_SINGLE_EE_P2UP: begin
                mode.eeprom_init = 1'b1;
                mode.upstream = swrst_pkg::UP_PORT2;
                mode.port0_dis = 1'b1;
            end
            swrst_pkg::CFG_MULTI: begin
                mode.multi = 1'b1;
            end
            swrst_pkg::CFG_MULTI_EE: begin
                mode.multi = 1'b1;
                mode.eeprom_init = 1'b1;
            end
            default: begin
                // Reserved codes leave the mode invalid; the sequencer still takes the switch out of reset to run.
                mode.valid = 1'b0;
            end
        endcase
    end

endmodule : swrst_mode_decode

// >>> verilog/swrst_ctrl.sv
// Fundamental reset sequencer, reset-halt hold and boot mode capture for the switch.
`timescale 1ns/100ps
module swrst_ctrl (
    // System clock, 100 MHz.
    input wire logic mclk,
    // Synchronous active-high power-on reset of this block.
    input wire logic rst,
    // Board fundamental reset, active low.
    input wire logic fundamental_reset_n,
    // Board reset-halt strap, active high.
    input wire logic reset_halt,
    // Board configuration select straps.
    input wire logic [3:0] switch_config_select,
    // Pulse from the SMBus register file: halt bit written to zero.
    input wire logic halt_clear_wr,
    // Reset to all switch core logic, active high.
    output logic core_reset,
    // Link fundamental reset request, active high.
    output logic link_fund_reset,
    // SMBus master and slave enable.
    output logic smbus_enable,
    // Halt bit value for the switch control register read-back.
    output logic switch_control_reg_halt,
    // Normal operation running.
    output logic run_active,
    // Captured and decoded operating mode.
    output swrst_pkg::swrst_mode_t mode
);

    // Sequencer state.
    swrst_pkg::swrst_state_t state_reg;
    swrst_pkg::swrst_state_t state_next;
    // Link reset pulse length counter.
    logic [3:0] lrst_cnt_reg;
    logic [3:0] lrst_cnt_next;
    // Captured straps.
    logic [3:0] cfg_reg;
    logic [3:0] cfg_next;
    // Halt bit of the switch control register; it also holds the captured halt strap.
    logic halt_bit_reg;
    logic halt_bit_next;
    // Registered outputs.
    logic core_reset_next;
    logic link_rst_next;
    logic smbus_en_next;
    logic run_next;
    swrst_pkg::swrst_mode_t mode_next;
    // Decoded mode from the captured code.
    swrst_pkg::swrst_mode_t mode_dec;

    // The decoder looks only at the captured code, never at the live pins.
    swrst_mode_decode u_decode (
        .cfg_code(cfg_reg),
        .mode(mode_dec)
    );

    // Next state of the sequencer, strap capture and halt bit.
    always_comb begin
        state_next = state_reg;
        lrst_cnt_next = lrst_cnt_reg;
        cfg_next = cfg_reg;
        halt_bit_next = halt_bit_reg;
        if (!fundamental_reset_n) begin
            // Reset wins from any state; straps are followed while it is held.
            state_next = swrst_pkg::SWRST_IN_RESET;
            lrst_cnt_next = swrst_pkg::LINK_RST_CYCLES;
            cfg_next = switch_config_select;
            halt_bit_next = reset_halt;
        end else begin
            unique case (state_reg)
                swrst_pkg::SWRST_IN_RESET: begin
                    // Release: values sampled in the last reset cycle stay frozen.
                    state_next = swrst_pkg::SWRST_LINK_RST;
                end
                swrst_pkg::SWRST_LINK_RST: begin
                    // Finish the link reset before deciding on halt or run.
                    if (lrst_cnt_reg == swrst_pkg::LINK_RST_CNT_ONE) begin
                        if (halt_bit_reg && !halt_clear_wr) begin
                            state_next = swrst_pkg::SWRST_HALT;
                        end else begin
                            state_next = swrst_pkg::SWRST_RUN;
                        end
                    end
                    if (lrst_cnt_reg != swrst_pkg::LINK_RST_CNT_ZERO) begin
                        lrst_cnt_next = lrst_cnt_reg - swrst_pkg::LINK_RST_CNT_ONE;
                    end
                    if (halt_clear_wr) begin
                        halt_bit_next = 1'b0;
                    end
                end
                swrst_pkg::SWRST_HALT: begin
                    // Only the SMBus master may release the hold.
                    if (halt_clear_wr) begin
                        halt_bit_next = 1'b0;
                        state_next = swrst_pkg::SWRST_RUN;
                    end
                end
                swrst_pkg::SWRST_RUN: begin
                    // Running; a late clear write is harmless.
                    halt_bit_next = 1'b0;
                end
            endcase
        end
    end

    // Output values; all outputs are registered so they are glitch free.
    always_comb begin
        core_reset_next = (state_next != swrst_pkg::SWRST_RUN);
        link_rst_next = (state_next == swrst_pkg::SWRST_IN_RESET)
            || (state_next == swrst_pkg::SWRST_LINK_RST);
        // SMBus must stay live while held so registers can be set up.
        smbus_en_next = (state_next == swrst_pkg::SWRST_HALT)
            || (state_next == swrst_pkg::SWRST_RUN);
        run_next = (state_next == swrst_pkg::SWRST_RUN);
        // Mode is shown only once the straps are frozen, and from the captured copy.
        mode_next = (state_next == swrst_pkg::SWRST_IN_RESET) ? '0 : mode_dec;
    end

    // Registers; synchronous reset puts the switch in fundamental reset.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= swrst_pkg::SWRST_IN_RESET;
            lrst_cnt_reg <= swrst_pkg::LINK_RST_CYCLES;
            cfg_reg <= swrst_pkg::CFG_SINGLE;
            halt_bit_reg <= 1'b0;
            core_reset <= 1'b1;
            link_fund_reset <= 1'b1;
            smbus_enable <= 1'b0;
            switch_control_reg_halt <= 1'b0;
            run_active <= 1'b0;
            mode <= '0;
        end else begin
            state_reg <= state_next;
            lrst_cnt_reg <= lrst_cnt_next;
            cfg_reg <= cfg_next;
            halt_bit_reg <= halt_bit_next;
            core_reset <= core_reset_next;
            link_fund_reset <= link_rst_next;
            smbus_enable <= smbus_en_next;
            switch_control_reg_halt <= halt_bit_next;
            run_active <= run_next;
            mode <= mode_next;
        end
    end

endmodule : swrst_ctrl

// >>> tb/swrst_ctrl_props.sv
// Port checker of the reset sequencer.
`timescale 1ns/100ps
module swrst_ctrl_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic fundamental_reset_n,
    input wire logic reset_halt,
    input wire logic [3:0] switch_config_select,
    input wire logic halt_clear_wr,
    input wire logic core_reset,
    input wire logic link_fund_reset,
    input wire logic smbus_enable,
    input wire logic switch_control_reg_halt,
    input wire logic run_active,
    input wire swrst_pkg::swrst_mode_t mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    rst_out_a: assert property (!fundamental_reset_n |=> core_reset && link_fund_reset
        && !smbus_enable && !run_active) else $error("reset levels wrong");
    link_hold_a: assert property ($rose(fundamental_reset_n) |=> link_fund_reset[*8])
        else $error("link reset short");
    link_end_a: assert property ($rose(fundamental_reset_n) ##1 fundamental_reset_n[*8]
        |=> !link_fund_reset && smbus_enable && core_reset == $past(reset_halt, 10))
        else $error("link reset end wrong");
    halt_hold_a: assert property (core_reset && smbus_enable && fundamental_reset_n
        && !halt_clear_wr |=> core_reset && smbus_enable && switch_control_reg_halt)
        else $error("halt not held");
    halt_exit_a: assert property (core_reset && smbus_enable && fundamental_reset_n
        && halt_clear_wr |=> run_active && !core_reset && !switch_control_reg_halt)
        else $error("halt exit wrong");
    run_out_a: assert property (run_active |-> smbus_enable && !core_reset
        && !link_fund_reset) else $error("run levels wrong");
    mode_hold_a: assert property (fundamental_reset_n[*3] |-> $stable(mode))
        else $error("mode moved");
    mode_kind_a: assert property ($rose(fundamental_reset_n) |=> mode.multi ==
        ($past(switch_config_select, 2) inside {4'hc, 4'hd})) else $error("multi wrong");
    cover property (smbus_enable && core_reset && halt_clear_wr);
    cover property ($rose(run_active));
    cover property (fundamental_reset_n && !mode.valid);
endmodule : swrst_ctrl_props
bind swrst_ctrl swrst_ctrl_props u_swrst_ctrl_props (.mclk, .rst, .fundamental_reset_n,
    .reset_halt, .switch_config_select, .halt_clear_wr, .core_reset, .link_fund_reset,
    .smbus_enable, .switch_control_reg_halt, .run_active, .mode);

// >>> tb/swrst_board.sv
// Board model: fundamental reset source and strap drivers.
`timescale 1ns/100ps
module swrst_board (
    input wire logic mclk,
    input wire logic hold_req,
    input wire logic halt_req,
    input wire logic [3:0] code_req,
    output logic fundamental_reset_n,
    output logic reset_halt,
    output logic [3:0] switch_config_select
);
    // Reset is asserted from time zero so the sequencer starts held.
    initial fundamental_reset_n = 1'b0;
    // Straps move only while reset is held, then stay put.
    always @(negedge mclk) begin
        fundamental_reset_n <= !hold_req;
        if (hold_req) begin
            reset_halt <= halt_req;
            // Reserved codes are presented on purpose to probe the quiet mode.
            switch_config_select <= code_req;
        end
    end
endmodule : swrst_board

// >>> tb/tb_top.sv
// Self-checking bench for the switch reset sequencer.
`timescale 1ns/100ps
module tb_top;
    logic mclk, rst, hold_req, halt_req, halt_clear_wr, fundamental_reset_n, reset_halt;
    logic core_reset, link_fund_reset, smbus_enable, switch_control_reg_halt, run_active;
    logic [3:0] code_req, switch_config_select;
    swrst_pkg::swrst_mode_t mode;
    logic [15:0] lfsr = 16'h6c62;
    int fail_count = 0, checks = 0, cycles = 0;
    // Expected {valid,multi,eeprom,upstream,p0off,p2off}; reserved codes give zero.
    localparam logic [6:0] EXP [16] = '{7'h40, 7'h50, 7'h0, 7'h0, 7'h0, 7'h0, 7'h0, 7'h0,
        7'h45, 7'h52, 7'h55, 7'h5a, 7'h60, 7'h70, 7'h0, 7'h0};
    swrst_board u_swrst_board (.mclk, .hold_req, .halt_req, .code_req, .fundamental_reset_n,
        .reset_halt, .switch_config_select);
    swrst_ctrl u_swrst_ctrl (.mclk, .rst, .fundamental_reset_n, .reset_halt,
        .switch_config_select, .halt_clear_wr, .core_reset, .link_fund_reset, .smbus_enable,
        .switch_control_reg_halt, .run_active, .mode);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    task automatic cmp_bit(input logic got, input logic want, input string what);
        checks++;
        if (got !== want) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : cmp_bit
    task automatic cmp_mode(input swrst_pkg::swrst_mode_t got, input logic [3:0] c);
        checks++;
        if (got !== EXP[c]) begin
            fail_count++;
            $display("mismatch at %0t: mode of code %h", $time, c);
        end
    endtask : cmp_mode
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // A hang counts as a mismatch and closes the run.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end
    // One full boot: hold reset, try an early clear, release, follow the sequence.
    task automatic boot(input logic [3:0] c, input logic h);
        hold_req <= 1'b1;
        code_req <= c;
        halt_req <= h;
        repeat (3) @(negedge mclk);
        cmp_bit(core_reset & link_fund_reset & ~smbus_enable, 1'b1, "reset levels");
        halt_clear_wr <= 1'b1;
        @(negedge mclk);
        halt_clear_wr <= 1'b0;
        hold_req <= 1'b0;
        cmp_bit(run_active, 1'b0, "clear in reset");
        repeat (2) @(negedge mclk);
        cmp_mode(mode, c);
        cmp_bit(switch_control_reg_halt, h, "halt readback");
        repeat (7) @(negedge mclk);
        cmp_bit(link_fund_reset, 1'b1, "link reset length");
        @(negedge mclk);
        cmp_bit(link_fund_reset | (core_reset ^ h), 1'b0, "link end");
        cmp_bit(smbus_enable, 1'b1, "smbus live");
        if (h) begin
            repeat (lfsr[3:0]) @(negedge mclk);
            cmp_bit(run_active, 1'b0, "still halted");
            halt_clear_wr <= 1'b1;
            @(negedge mclk);
            halt_clear_wr <= 1'b0;
            cmp_bit(run_active & ~core_reset & ~switch_control_reg_halt, 1'b1, "exit");
        end
        cmp_mode(mode, c);
        $display("test code %h halt %b done", c, h);
    endtask : boot
    initial begin
        rst = 1'b1;
        hold_req = 1'b1;
        halt_req = 1'b0;
        code_req = 4'h0;
        halt_clear_wr = 1'b0;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            lfsr = step(lfsr);
            boot(i < 16 ? i[3:0] : lfsr[7:4], lfsr[8]);
        end
        rst <= 1'b1;
        hold_req <= 1'b1;
        repeat (2) @(negedge mclk);
        rst <= 1'b0;
        boot(4'hd, 1'b1);
        end_sim();
    end
endmodule : tb_top
